// ==== hdl/pin_cfg_pkg.sv ====
// Summary of operation
// - Enable pin low turns high-speed channels off into standby; high turns them on.
// - Source-select code 00..11 routes lanes of source A..D to the output lanes.
// - In pin mode the auxiliary switch stays enabled always.
// - Source-select code 00..11 also routes auxiliary lines to auxiliary source A..D.
// - In pin mode all high-speed input terminations stay enabled.
// - In pin mode pulse-on-source-switch stays disabled for all four sources.
// - One equalization pin sets every input channel of every source together.
// - Equalization pin 0 selects 6 dB, 1 selects 12 dB.
// - Pre-emphasis pins 00, 01, 10, 11 give 0, 2, 4, 6 dB.
// - Output-termination pin 0 disables, 1 enables output terminations.
// - Output-current pin 0 selects 10 mA, 1 selects 20 mA.
// - Pins rule only from reset until first serial access; board ties them fixed.
package pin_cfg_pkg;

  // ==========================================================
  // Register indices
  localparam int unsigned REG_COUNT = 8;
  localparam logic [2:0] IDX_HIGH_SPEED_MODES = 3'h0;
  localparam logic [2:0] IDX_AUXILIARY_MODES = 3'h1;
  localparam logic [2:0] IDX_RECEIVER_SETTINGS = 3'h2;
  localparam logic [2:0] IDX_INPUT_TERM_PULSE_ONE = 3'h3;
  localparam logic [2:0] IDX_INPUT_TERM_PULSE_TWO = 3'h4;
  localparam logic [2:0] IDX_RECEIVE_EQUALIZER_ONE = 3'h5;
  localparam logic [2:0] IDX_RECEIVE_EQUALIZER_TWO = 3'h6;
  localparam logic [2:0] IDX_TRANSMITTER_SETTINGS = 3'h7;

  // ==========================================================
  // Field positions
  localparam int unsigned POS_CHANNEL_ENABLE = 6;
  localparam int unsigned POS_AUX_ENABLE = 6;
  localparam int unsigned POS_SOURCE_LSB = 0;
  localparam int unsigned POS_INPUT_TERM = 0;
  localparam int unsigned POS_PREEMPH_LSB = 2;
  localparam int unsigned POS_OUTPUT_TERM = 1;
  localparam int unsigned POS_OUTPUT_CURRENT = 0;

  // ==========================================================
  // Fixed values in pin mode and reset values
  localparam logic [7:0] FIXED_AUX_ENABLE = 8'h40;
  localparam logic [7:0] FIXED_INPUT_TERM = 8'h01;
  localparam logic [7:0] FIXED_PULSE_OFF = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ==========================================================
  // Encodings
  localparam logic [1:0] SOURCE_A = 2'h0;
  localparam logic [1:0] SOURCE_B = 2'h1;
  localparam logic [1:0] SOURCE_C = 2'h2;
  localparam logic [1:0] SOURCE_D = 2'h3;
  localparam logic EQ_6DB = 1'b0;
  localparam logic EQ_12DB = 1'b1;
  localparam logic [1:0] PREEMPH_0DB = 2'h0;
  localparam logic [1:0] PREEMPH_2DB = 2'h1;
  localparam logic [1:0] PREEMPH_4DB = 2'h2;
  localparam logic [1:0] PREEMPH_6DB = 2'h3;
  localparam logic CURRENT_10MA = 1'b0;
  localparam logic CURRENT_20MA = 1'b1;
  localparam int unsigned PIN_COUNT = 8;

  typedef logic [REG_COUNT-1:0][7:0] reg_image_t;

  typedef struct packed {
    logic channel_enable;
    logic pin_equalization_level;
    logic [1:0] pin_source_select;
    logic [1:0] pin_preemphasis_level;
    logic pin_output_termination;
    logic pin_output_current;
  } strap_t;

  typedef struct packed {
    logic hs_channels_on;
    logic standby;
    logic [1:0] hs_source_select;
    logic aux_switch_enable;
    logic [1:0] aux_source_select;
    logic input_termination_on;
    logic [15:0] term_pulse_enable;
    logic [15:0] equalizer_high;
    logic [1:0] preemphasis_level;
    logic output_termination_on;
    logic output_current_high;
  } link_settings_t;

  localparam reg_image_t RESET_IMAGE = {RESET_BYTE, RESET_BYTE, RESET_BYTE, RESET_BYTE,
                                        RESET_BYTE, FIXED_INPUT_TERM, FIXED_AUX_ENABLE,
                                        RESET_BYTE};

endpackage

// ==== hdl/strap_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_q;

  // Refuse an empty strap bus at elaboration
  if (WIDTH < 1)
  begin
    $error("strap_sync needs WIDTH of at least one");
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage_q <= async_in;
      sync_out <= stage_q;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/parallel_pin_config_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module parallel_pin_config_decoder (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Strap pins
  input wire logic pin_channel_enable,
  input wire logic [1:0] pin_source_select,
  input wire logic pin_equalization_level,
  input wire logic [1:0] pin_preemphasis_level,
  input wire logic pin_output_termination,
  input wire logic pin_output_current,
  // Register access from the serial control logic
  input wire logic reg_access_valid,
  input wire logic reg_access_write,
  input wire logic [2:0] reg_access_addr,
  input wire logic [7:0] reg_write_data,
  output logic [7:0] reg_read_data,
  output logic reg_read_valid,
  // Settings to the switch fabric
  output logic pin_mode_active,
  output var pin_cfg_pkg::link_settings_t settings
);
  import pin_cfg_pkg::*;

  strap_t strap_raw;
  strap_t strap_sync_lvl;
  reg_image_t image_q;
  logic serial_owned_q;

  // ==========================================================
  // Pin image
  function automatic reg_image_t pin_image(input strap_t s);
    reg_image_t img;
    img = RESET_IMAGE;
    img[IDX_HIGH_SPEED_MODES][POS_CHANNEL_ENABLE] = s.channel_enable;
    img[IDX_HIGH_SPEED_MODES][POS_SOURCE_LSB +: 2] = s.pin_source_select;
    img[IDX_AUXILIARY_MODES] = FIXED_AUX_ENABLE;
    img[IDX_AUXILIARY_MODES][POS_SOURCE_LSB +: 2] = s.pin_source_select;
    img[IDX_RECEIVER_SETTINGS] = FIXED_INPUT_TERM;
    img[IDX_INPUT_TERM_PULSE_ONE] = FIXED_PULSE_OFF;
    img[IDX_INPUT_TERM_PULSE_TWO] = FIXED_PULSE_OFF;
    img[IDX_RECEIVE_EQUALIZER_ONE] = {8{s.pin_equalization_level}};
    img[IDX_RECEIVE_EQUALIZER_TWO] = {8{s.pin_equalization_level}};
    img[IDX_TRANSMITTER_SETTINGS][POS_PREEMPH_LSB +: 2] = s.pin_preemphasis_level;
    img[IDX_TRANSMITTER_SETTINGS][POS_OUTPUT_TERM] = s.pin_output_termination;
    img[IDX_TRANSMITTER_SETTINGS][POS_OUTPUT_CURRENT] = s.pin_output_current;
    return img;
  endfunction

  // ==========================================================
  // Settings decode
  function automatic link_settings_t decode(input reg_image_t img);
    link_settings_t d;
    d.hs_channels_on = img[IDX_HIGH_SPEED_MODES][POS_CHANNEL_ENABLE];
    d.standby = ~img[IDX_HIGH_SPEED_MODES][POS_CHANNEL_ENABLE];
    d.hs_source_select = img[IDX_HIGH_SPEED_MODES][POS_SOURCE_LSB +: 2];
    d.aux_switch_enable = img[IDX_AUXILIARY_MODES][POS_AUX_ENABLE];
    d.aux_source_select = img[IDX_AUXILIARY_MODES][POS_SOURCE_LSB +: 2];
    d.input_termination_on = img[IDX_RECEIVER_SETTINGS][POS_INPUT_TERM];
    d.term_pulse_enable = {img[IDX_INPUT_TERM_PULSE_TWO], img[IDX_INPUT_TERM_PULSE_ONE]};
    // Bit 1 means 12 dB, bit 0 means 6 dB
    d.equalizer_high = {img[IDX_RECEIVE_EQUALIZER_TWO], img[IDX_RECEIVE_EQUALIZER_ONE]};
    d.preemphasis_level = img[IDX_TRANSMITTER_SETTINGS][POS_PREEMPH_LSB +: 2];
    d.output_termination_on = img[IDX_TRANSMITTER_SETTINGS][POS_OUTPUT_TERM];
    d.output_current_high = img[IDX_TRANSMITTER_SETTINGS][POS_OUTPUT_CURRENT];
    return d;
  endfunction

  // Settings during reset, fixed at elaboration
  localparam link_settings_t RESET_SETTINGS = decode(RESET_IMAGE);

  // ==========================================================
  // Pin synchronisers
  assign strap_raw = '{channel_enable: pin_channel_enable,
                       pin_equalization_level: pin_equalization_level,
                       pin_source_select: pin_source_select,
                       pin_preemphasis_level: pin_preemphasis_level,
                       pin_output_termination: pin_output_termination,
                       pin_output_current: pin_output_current};

  strap_sync #(
    .WIDTH(PIN_COUNT)
  ) u_strap_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(strap_raw),
    .sync_out(strap_sync_lvl)
  );

  // ==========================================================
  // Ownership flag
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_owned_q <= 1'b0;
    end
    else if (reg_access_valid)
    begin
      serial_owned_q <= 1'b1;
    end
  end

  // ==========================================================
  // Register image
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      image_q <= RESET_IMAGE;
    end
    else if (reg_access_valid && reg_access_write)
    begin
      // Serial write replaces one byte; the others keep their last values
      image_q[reg_access_addr] <= reg_write_data;
    end
    else if (!serial_owned_q && !reg_access_valid)
    begin
      image_q <= pin_image(strap_sync_lvl);
    end
  end

  // ==========================================================
  // Register read
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_read_data <= RESET_BYTE;
      reg_read_valid <= 1'b0;
    end
    else
    begin
      reg_read_valid <= reg_access_valid && !reg_access_write;
      if (reg_access_valid && !reg_access_write)
      begin
        reg_read_data <= image_q[reg_access_addr];
      end
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settings <= RESET_SETTINGS;
      pin_mode_active <= 1'b1;
    end
    else
    begin
      settings <= decode(image_q);
      pin_mode_active <= ~serial_owned_q;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/config_decoder_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module config_decoder_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Strap pins
  input wire logic pin_channel_enable,
  input wire logic [1:0] pin_source_select,
  input wire logic pin_equalization_level,
  input wire logic [1:0] pin_preemphasis_level,
  input wire logic pin_output_termination,
  input wire logic pin_output_current,
  // Register port
  input wire logic reg_access_valid,
  input wire logic reg_access_write,
  input wire logic [2:0] reg_access_addr,
  input wire logic [7:0] reg_write_data,
  input wire logic [7:0] reg_read_data,
  input wire logic reg_read_valid,
  // Settings
  input wire logic pin_mode_active,
  input wire pin_cfg_pkg::link_settings_t settings
);
  import pin_cfg_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic [7:0] straps = {pin_channel_enable, pin_source_select, pin_equalization_level,
                             pin_preemphasis_level, pin_output_termination, pin_output_current};
  wire logic pm = pin_mode_active;
  // ==========================================================
  // Pin mode
  a_standby_inverse: assert property (settings.standby == !settings.hs_channels_on)
    else $error("standby not inverse");
  a_aux_always_on: assert property (pm |-> settings.aux_switch_enable)
    else $error("aux switch off");
  a_aux_same_source: assert property (pm |->
    settings.aux_source_select == settings.hs_source_select)
    else $error("aux source differs");
  a_input_term_on: assert property (pm |-> settings.input_termination_on)
    else $error("input term off");
  a_pulse_off: assert property (pm |-> settings.term_pulse_enable == 16'h0000)
    else $error("pulse enabled");
  a_eq_uniform: assert property (pm |->
    settings.equalizer_high inside {16'h0000, 16'hffff})
    else $error("eq not uniform");
  a_pins_decoded: assert property (
    (pm && !reg_access_valid && $stable(straps))[*6] |->
    settings.hs_channels_on == pin_channel_enable && settings.hs_source_select == pin_source_select
    && settings.equalizer_high[0] == pin_equalization_level
    && settings.preemphasis_level == pin_preemphasis_level
    && settings.output_termination_on == pin_output_termination
    && settings.output_current_high == pin_output_current)
    else $error("pins not decoded");
  // ==========================================================
  // Serial ownership
  // Read strobe one edge after the access, pin mode flag low one edge later
  a_access_takes_over: assert property (reg_access_valid |=>
    (reg_read_valid == !$past(reg_access_write)) ##1 !pm)
    else $error("access not taken");
  a_pins_locked_out: assert property (!pm && !reg_access_valid |=>
    !pm ##1 $stable(settings))
    else $error("pins not locked out");
endmodule
`default_nettype wire

// ==== testbench/strap_board.sv ====
`timescale 1ns/1ps
`default_nettype none
module strap_board (
  // Chosen strap
  input wire pin_cfg_pkg::strap_t strap,
  // Pin levels
  output logic pin_channel_enable,
  output logic [1:0] pin_source_select,
  output logic pin_equalization_level,
  output logic [1:0] pin_preemphasis_level,
  output logic pin_output_termination,
  output logic pin_output_current
);
  import pin_cfg_pkg::*;
  // Every pin tied to a solid level
  assign {pin_channel_enable, pin_equalization_level, pin_source_select, pin_preemphasis_level,
          pin_output_termination, pin_output_current} = strap;
endmodule
`default_nettype wire

// ==== testbench/tb_parallel_pin_config_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_pin_config_decoder;
  import pin_cfg_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  strap_t strap = '0;
  logic reg_access_valid = 1'b0;
  logic reg_access_write = 1'b0;
  logic [2:0] reg_access_addr = 3'h0;
  logic [7:0] reg_write_data = 8'h00;
  wire logic pin_channel_enable, pin_equalization_level;
  wire logic pin_output_termination, pin_output_current;
  wire logic [1:0] pin_source_select, pin_preemphasis_level;
  logic [7:0] reg_read_data;
  logic reg_read_valid, pin_mode_active;
  link_settings_t settings;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  initial forever #4 mclk = ~mclk;
  strap_board strap_board_i (.strap(strap), .pin_channel_enable(pin_channel_enable),
    .pin_source_select(pin_source_select), .pin_equalization_level(pin_equalization_level),
    .pin_preemphasis_level(pin_preemphasis_level),
    .pin_output_termination(pin_output_termination), .pin_output_current(pin_output_current));
  parallel_pin_config_decoder parallel_pin_config_decoder_i (.mclk(mclk), .rst_n(rst_n),
    .pin_channel_enable(pin_channel_enable), .pin_source_select(pin_source_select),
    .pin_equalization_level(pin_equalization_level),
    .pin_preemphasis_level(pin_preemphasis_level),
    .pin_output_termination(pin_output_termination), .pin_output_current(pin_output_current),
    .reg_access_valid(reg_access_valid), .reg_access_write(reg_access_write),
    .reg_access_addr(reg_access_addr), .reg_write_data(reg_write_data),
    .reg_read_data(reg_read_data), .reg_read_valid(reg_read_valid),
    .pin_mode_active(pin_mode_active), .settings(settings));
  function automatic link_settings_t expect_of(input strap_t s);
    link_settings_t e;
    e = '0;
    e.hs_channels_on = s.channel_enable;
    e.standby = !s.channel_enable;
    e.hs_source_select = s.pin_source_select;
    e.aux_switch_enable = 1'b1;
    e.aux_source_select = s.pin_source_select;
    e.input_termination_on = 1'b1;
    e.equalizer_high = {16{s.pin_equalization_level}};
    e.preemphasis_level = s.pin_preemphasis_level;
    e.output_termination_on = s.pin_output_termination;
    e.output_current_high = s.pin_output_current;
    return e;
  endfunction
  task automatic check_settings(input link_settings_t exp);
    num_checks++;
    if (settings !== exp)
    begin
      failures++;
      $display("wrong value at %0t: settings %h, expected %h", $time, settings, exp);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic restart(input strap_t s);
    @(negedge mclk);
    strap = s;
    rst_n = 1'b0;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
  endtask
  task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic rv);
    @(negedge mclk);
    reg_access_valid = 1'b1;
    reg_access_write = w;
    reg_access_addr = a;
    reg_write_data = d;
    @(negedge mclk);
    // Read strobe stands for this one cycle only
    rd = reg_read_data;
    rv = reg_read_valid;
    reg_access_valid = 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      failures++;
      print_verdict;
    end
  end
  initial
  begin
    strap_t s;
    link_settings_t e;
    logic [7:0] rd;
    logic rv;
    logic [7:0] image [8];
    // Frozen image of the last strap: on, source 11, eq 1, preemph 00, term on, 10 mA
    image = '{8'h43, 8'h43, 8'h01, 8'h00, 8'h00, 8'hff, 8'hff, 8'h02};
    for (int i = 0; i < 4; i++)
    begin
      s = {i[0], i[1], i[1:0], ~i[1:0], i[0], ~i[0]};
      restart(s);
      check_settings(expect_of(s));
    end
    for (int a = 0; a < 8; a++)
    begin
      access(1'b0, a[2:0], 8'h00, rd, rv);
      check_byte(rd, image[a]);
      check_byte({7'h00, rv}, 8'h01);
    end
    strap = ~s;
    repeat (8) @(negedge mclk);
    check_settings(expect_of(s));
    access(1'b1, IDX_TRANSMITTER_SETTINGS, 8'h0d, rd, rv);
    repeat (2) @(negedge mclk);
    e = expect_of(s);
    e.preemphasis_level = PREEMPH_6DB;
    e.output_termination_on = 1'b0;
    e.output_current_high = CURRENT_20MA;
    check_settings(e);
    restart(s);
    check_byte({7'h00, pin_mode_active}, 8'h01);
    check_settings(expect_of(s));
    print_verdict;
  end
endmodule
bind parallel_pin_config_decoder config_decoder_props config_decoder_props_i (.mclk(mclk),
  .rst_n(rst_n), .pin_channel_enable(pin_channel_enable), .pin_source_select(pin_source_select),
  .pin_equalization_level(pin_equalization_level), .pin_preemphasis_level(pin_preemphasis_level),
  .pin_output_termination(pin_output_termination), .pin_output_current(pin_output_current),
  .reg_access_valid(reg_access_valid), .reg_access_write(reg_access_write),
  .reg_access_addr(reg_access_addr), .reg_write_data(reg_write_data),
  .reg_read_data(reg_read_data), .reg_read_valid(reg_read_valid),
  .pin_mode_active(pin_mode_active), .settings(settings));
`default_nettype wire
